// *** ams_pkg.sv ***
package ams_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_OPER  = 8'h04;
    localparam logic [7:0] OFF_BASE  = 8'h08;
    localparam logic [7:0] OFF_INDEX = 8'h0c;
    localparam logic [7:0] OFF_FLAGS = 8'h10;
    localparam logic [7:0] OFF_XADDR = 8'h14;
    localparam logic [7:0] OFF_WBVAL = 8'h18;
    localparam logic [7:0] OFF_STAT  = 8'h1c;

    // control register fields
    localparam int unsigned CTRL_CLASS_LSB = 0;
    localparam int unsigned CTRL_FORM_LSB  = 2;
    localparam int unsigned CTRL_UP_BIT    = 4;
    localparam int unsigned CTRL_REG_BIT   = 5;
    localparam int unsigned CTRL_SHIFT_LSB = 6;
    localparam int unsigned CTRL_USER_BIT  = 8;
    localparam int unsigned CTRL_LOAD_BIT  = 9;
    localparam int unsigned CTRL_STACK_LSB = 10;
    localparam int unsigned CTRL_COND_LSB  = 12;
    localparam int unsigned CTRL_MASK_LSB  = 16;
    localparam logic [31:0] CTRL_RST       = 32'h0000_e000;

    // operand register fields
    localparam int unsigned OPER_IMM12_LSB = 0;
    localparam int unsigned OPER_SAMT_LSB  = 16;
    localparam int unsigned OPER_CNT_LSB   = 24;

    // flags register fields
    localparam int unsigned FLAG_V_BIT = 0;
    localparam int unsigned FLAG_C_BIT = 1;
    localparam int unsigned FLAG_Z_BIT = 2;
    localparam int unsigned FLAG_N_BIT = 3;

    // status register fields
    localparam int unsigned STAT_PASS_BIT  = 0;
    localparam int unsigned STAT_ILL_BIT   = 1;
    localparam int unsigned STAT_XFER_BIT  = 2;
    localparam int unsigned STAT_WB_BIT    = 3;
    localparam int unsigned STAT_ORDER_LSB = 4;
    localparam int unsigned STAT_FSEL_LSB  = 8;

    localparam int unsigned WORD_LOG2 = 2;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

    typedef enum logic [1:0] {CL_WORD, CL_HALF, CL_MULTI, CL_COPROC} ams_class_e;
    typedef enum logic [1:0] {FM_OFFSET, FM_PRE, FM_POST, FM_RSVD} ams_form_e;
    typedef enum logic [1:0] {SH_LSL, SH_LSR, SH_ASR, SH_ROR} ams_shift_e;
    typedef enum logic [1:0] {
        full_descending_stack, empty_descending_stack, full_ascending_stack, empty_ascending_stack
    } ams_stack_e;
    typedef enum logic [1:0] {increment_after, increment_before, decrement_after, decrement_before} ams_order_e;
    typedef enum logic [3:0] {
        cond_equal, cond_not_equal, cond_unsigned_ge, cond_unsigned_lt,
        cond_negative, cond_nonnegative, cond_overflow, cond_no_overflow,
        cond_unsigned_gt, cond_unsigned_le, cond_signed_ge, cond_signed_lt,
        cond_signed_gt, cond_signed_le, cond_always, cond_reserved
    } ams_cond_e;

endpackage

// *** ams_shifter.sv ***
`timescale 1ns/100ps
`default_nettype none
module ams_shifter #(
    parameter int unsigned W = 32
) (
    input  wire logic [W-1:0]           value,
    input  wire ams_pkg::ams_shift_e    kind,
    input  wire logic [4:0]             amount,
    input  wire logic                   carry_in,
    output logic      [W-1:0]           result
);
    logic [2*W-1:0] rot;

    always_comb begin
        rot = {value, value} >> amount;
        case (kind)
            ams_pkg::SH_LSL: result = value << amount;
            ams_pkg::SH_LSR: result = value >> amount;
            ams_pkg::SH_ASR: result = W'($signed(value) >>> amount);
            ams_pkg::SH_ROR: begin
                // a zero rotate amount selects rotate_through_carry
                if (amount == 5'h00) begin
                    result = {carry_in, value[W-1:1]};
                end else begin
                    result = rot[W-1:0];
                end
            end
            default: result = value;
        endcase
    end
endmodule
`default_nettype wire

// *** ams_addr_decode.sv ***
// Notes on behaviour
// RQ1: word/byte offsets are a 12-bit immediate or an index register shifted by a 5-bit amount or rotated through carry, added to or subtracted from the base.
// RQ2: pre-indexed form uses base plus/minus offset as the address and writes that address back to the base.
// RQ3: post-indexed form uses the unmodified base as the address and then updates the base by the offset.
// RQ4: user-privilege word/byte transfers accept only the offset and post-indexed forms, never pre-indexed.
// RQ5: multiple loads map full-descending, empty-descending, full-ascending, empty-ascending to increment-after, increment-before, decrement-after, decrement-before.
// RQ6: multiple stores map empty-ascending, full-ascending, empty-descending, full-descending to increment-after, increment-before, decrement-after, decrement-before.
// RQ7: coprocessor transfers scale an 8-bit immediate by four in offset, pre-indexed and post-indexed forms.
// RQ8: the status-write mask selects control, extension, status and flags fields by bits 0 to 3.
// RQ9: fifteen condition predicates from equal to always are evaluated against the flags.
// RQ10: a failed predicate changes nothing and performs no base writeback.
// RQ11: halfword, signed-byte and doubleword transfers use an 8-bit immediate or an unshifted index register.
`timescale 1ns/100ps
`default_nettype none
module ams_addr_decode (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ams_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [ams_pkg::DATA_W-1:0]    pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [ams_pkg::DATA_W-1:0]    prdata,
    output logic                               pready,
    output logic                               pslverr
);
    logic [31:0]          ctrl_q, oper_q, base_q, index_q, flags_q;
    logic [31:0]          xaddr_q, xaddr_d, wbval_q, wbval_d, stat_q, stat_d;
    logic [31:0]          prdata_q, rd_mux;
    logic                 wr_ok, rd_map, wr_map;
    ams_pkg::ams_class_e  cls;
    ams_pkg::ams_form_e   form;
    ams_pkg::ams_shift_e  skind;
    ams_pkg::ams_stack_e  stack;
    ams_pkg::ams_cond_e   cond;
    ams_pkg::ams_order_e  order;
    logic                 up, use_reg, user, load;
    logic                 fn, fz, fc, fv;
    logic [3:0]           fmask;
    logic [4:0]           samt, cnt;
    logic [11:0]          imm12;
    logic [7:0]           imm8;
    logic [31:0]          shifted, off, sum, span;
    logic                 pass, illegal, wb_req;

    assign cls     = ams_pkg::ams_class_e'(ctrl_q[ams_pkg::CTRL_CLASS_LSB +: 2]);
    assign form    = ams_pkg::ams_form_e'(ctrl_q[ams_pkg::CTRL_FORM_LSB +: 2]);
    assign skind   = ams_pkg::ams_shift_e'(ctrl_q[ams_pkg::CTRL_SHIFT_LSB +: 2]);
    assign stack   = ams_pkg::ams_stack_e'(ctrl_q[ams_pkg::CTRL_STACK_LSB +: 2]);
    assign cond    = ams_pkg::ams_cond_e'(ctrl_q[ams_pkg::CTRL_COND_LSB +: 4]);
    assign fmask   = ctrl_q[ams_pkg::CTRL_MASK_LSB +: 4];
    assign up      = ctrl_q[ams_pkg::CTRL_UP_BIT];
    assign use_reg = ctrl_q[ams_pkg::CTRL_REG_BIT];
    assign user    = ctrl_q[ams_pkg::CTRL_USER_BIT];
    assign load    = ctrl_q[ams_pkg::CTRL_LOAD_BIT];
    assign imm12   = oper_q[ams_pkg::OPER_IMM12_LSB +: 12];
    assign imm8    = oper_q[ams_pkg::OPER_IMM12_LSB +: 8];
    assign samt    = oper_q[ams_pkg::OPER_SAMT_LSB +: 5];
    assign cnt     = oper_q[ams_pkg::OPER_CNT_LSB +: 5];
    assign fn      = flags_q[ams_pkg::FLAG_N_BIT];
    assign fz      = flags_q[ams_pkg::FLAG_Z_BIT];
    assign fc      = flags_q[ams_pkg::FLAG_C_BIT];
    assign fv      = flags_q[ams_pkg::FLAG_V_BIT];

    ams_shifter #(.W(32)) u_shift (
        .value    (index_q),
        .kind     (skind),
        .amount   (samt),
        .carry_in (fc),
        .result   (shifted)
    );

    // condition predicate on the current flags
    always_comb begin
        case (cond)
            ams_pkg::cond_equal:       pass = fz;                       // RQ9
            ams_pkg::cond_not_equal:   pass = !fz;                      // RQ9
            ams_pkg::cond_unsigned_ge: pass = fc;                       // RQ9
            ams_pkg::cond_unsigned_lt: pass = !fc;                      // RQ9
            ams_pkg::cond_negative:    pass = fn;                       // RQ9
            ams_pkg::cond_nonnegative: pass = !fn;                      // RQ9
            ams_pkg::cond_overflow:    pass = fv;                       // RQ9
            ams_pkg::cond_no_overflow: pass = !fv;                      // RQ9
            ams_pkg::cond_unsigned_gt: pass = fc && !fz;                // RQ9
            ams_pkg::cond_unsigned_le: pass = !fc || fz;                // RQ9
            ams_pkg::cond_signed_ge:   pass = (fn == fv);               // RQ9
            ams_pkg::cond_signed_lt:   pass = (fn != fv);               // RQ9
            ams_pkg::cond_signed_gt:   pass = !fz && (fn == fv);        // RQ9
            ams_pkg::cond_signed_le:   pass = fz || (fn != fv);         // RQ9
            ams_pkg::cond_always:      pass = 1'b1;                     // RQ9
            default:                   pass = 1'b0;
        endcase
    end

    // stack name to transfer order
    always_comb begin
        if (load) begin
            case (stack)
                ams_pkg::full_descending_stack:  order = ams_pkg::increment_after;   // RQ5
                ams_pkg::empty_descending_stack: order = ams_pkg::increment_before;  // RQ5
                ams_pkg::full_ascending_stack:   order = ams_pkg::decrement_after;   // RQ5
                default:                         order = ams_pkg::decrement_before;  // RQ5
            endcase
        end else begin
            case (stack)
                ams_pkg::empty_ascending_stack:  order = ams_pkg::increment_after;   // RQ6
                ams_pkg::full_ascending_stack:   order = ams_pkg::increment_before;  // RQ6
                ams_pkg::empty_descending_stack: order = ams_pkg::decrement_after;   // RQ6
                default:                         order = ams_pkg::decrement_before;  // RQ6
            endcase
        end
    end

    // offset selection and address forming
    always_comb begin
        span = 32'(cnt) << ams_pkg::WORD_LOG2;
        case (cls)
            ams_pkg::CL_WORD:   off = use_reg ? shifted : 32'(imm12);                // RQ1
            ams_pkg::CL_HALF:   off = use_reg ? index_q : 32'(imm8);                 // RQ11
            ams_pkg::CL_COPROC: off = 32'(imm8) << ams_pkg::WORD_LOG2;               // RQ7
            default:            off = span;
        endcase
        sum     = up ? base_q + off : base_q - off;                                  // RQ1
        wb_req  = (form == ams_pkg::FM_PRE) || (form == ams_pkg::FM_POST);
        // a reserved form or condition is refused rather than guessed at
        illegal = (form == ams_pkg::FM_RSVD) || (cond == ams_pkg::cond_reserved)
                  || (cls == ams_pkg::CL_WORD && user && form == ams_pkg::FM_PRE);   // RQ4
        if (cls == ams_pkg::CL_MULTI) begin
            case (order)
                ams_pkg::increment_after:  xaddr_d = base_q;
                ams_pkg::increment_before: xaddr_d = base_q + ams_pkg::WORD_BYTES;
                ams_pkg::decrement_after:  xaddr_d = base_q - span + ams_pkg::WORD_BYTES;
                default:                   xaddr_d = base_q - span;
            endcase
            wbval_d = (order == ams_pkg::increment_after || order == ams_pkg::increment_before)
                      ? base_q + span : base_q - span;
        end else begin
            xaddr_d = (form == ams_pkg::FM_POST) ? base_q : sum;                     // RQ2 RQ3
            wbval_d = sum;                                                           // RQ2 RQ3
        end
        stat_d = 32'h0000_0000;
        stat_d[ams_pkg::STAT_PASS_BIT]       = pass;
        stat_d[ams_pkg::STAT_ILL_BIT]        = illegal;
        stat_d[ams_pkg::STAT_XFER_BIT]       = pass && !illegal;                     // RQ10
        stat_d[ams_pkg::STAT_WB_BIT]         = pass && !illegal && wb_req;           // RQ10
        stat_d[ams_pkg::STAT_ORDER_LSB +: 2] = order;
        stat_d[ams_pkg::STAT_FSEL_LSB +: 4]  = pass ? fmask : 4'h0;                  // RQ8
    end

    // results are re-formed every cycle from the programmed registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xaddr_q <= 32'h0000_0000;
            wbval_q <= 32'h0000_0000;
            stat_q  <= 32'h0000_0000;
        end else begin
            xaddr_q <= xaddr_d;
            wbval_q <= wbval_d;
            stat_q  <= stat_d;
        end
    end

    // apb slave, zero wait states
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    assign wr_map = (paddr == ams_pkg::OFF_CTRL) || (paddr == ams_pkg::OFF_OPER) || (paddr == ams_pkg::OFF_BASE)
                    || (paddr == ams_pkg::OFF_INDEX) || (paddr == ams_pkg::OFF_FLAGS);
    assign rd_map = wr_map || (paddr == ams_pkg::OFF_XADDR) || (paddr == ams_pkg::OFF_WBVAL)
                    || (paddr == ams_pkg::OFF_STAT);
    assign wr_ok  = psel && penable && pwrite && wr_map;
    assign pready = 1'b1;
    // writes to result registers or holes are errored, not silently dropped
    assign pslverr = psel && penable && (pwrite ? !wr_map : !rd_map);
    assign prdata  = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= ams_pkg::CTRL_RST;
            oper_q  <= 32'h0000_0000;
            base_q  <= 32'h0000_0000;
            index_q <= 32'h0000_0000;
            flags_q <= 32'h0000_0000;
        end else if (wr_ok) begin
            case (paddr)
                ams_pkg::OFF_CTRL:  ctrl_q  <= merge(ctrl_q, pwdata, pstrb);
                ams_pkg::OFF_OPER:  oper_q  <= merge(oper_q, pwdata, pstrb);
                ams_pkg::OFF_BASE:  base_q  <= merge(base_q, pwdata, pstrb);
                ams_pkg::OFF_INDEX: index_q <= merge(index_q, pwdata, pstrb);
                ams_pkg::OFF_FLAGS: flags_q <= merge(flags_q, pwdata, pstrb);
                default:            flags_q <= flags_q;
            endcase
        end
    end

    always_comb begin
        case (paddr)
            ams_pkg::OFF_CTRL:  rd_mux = ctrl_q;
            ams_pkg::OFF_OPER:  rd_mux = oper_q;
            ams_pkg::OFF_BASE:  rd_mux = base_q;
            ams_pkg::OFF_INDEX: rd_mux = index_q;
            ams_pkg::OFF_FLAGS: rd_mux = flags_q;
            ams_pkg::OFF_XADDR: rd_mux = xaddr_q;
            ams_pkg::OFF_WBVAL: rd_mux = wbval_q;
            ams_pkg::OFF_STAT:  rd_mux = stat_q;
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // read data captured in the setup phase so it is a flop at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_word_imm_off: assert property (cls == ams_pkg::CL_WORD && !use_reg && form == ams_pkg::FM_OFFSET && up // RQ1
        |=> xaddr_q == $past(base_q) + 32'($past(imm12))) else $error("word immediate offset address wrong");
    a_pre_wb_addr: assert property (cls != ams_pkg::CL_MULTI && form == ams_pkg::FM_PRE && pass && !illegal // RQ2
        |=> stat_q[ams_pkg::STAT_WB_BIT] && wbval_q == xaddr_q) else $error("pre-indexed writeback mismatch");
    a_post_base: assert property (cls != ams_pkg::CL_MULTI && form == ams_pkg::FM_POST // RQ3
        |=> xaddr_q == $past(base_q) && wbval_q == $past(sum)) else $error("post-indexed address not base");
    a_user_no_pre: assert property (cls == ams_pkg::CL_WORD && user && form == ams_pkg::FM_PRE // RQ4
        |=> stat_q[ams_pkg::STAT_ILL_BIT] && !stat_q[ams_pkg::STAT_WB_BIT]) else $error("user pre-index accepted");
    a_load_fd_ia: assert property (cls == ams_pkg::CL_MULTI && load && stack == ams_pkg::full_descending_stack // RQ5
        |=> stat_q[ams_pkg::STAT_ORDER_LSB +: 2] == 2'h0 && xaddr_q == $past(base_q)) else $error("load stack map");
    a_store_fd_db: assert property (cls == ams_pkg::CL_MULTI && !load && stack == ams_pkg::full_descending_stack // RQ6
        |=> stat_q[ams_pkg::STAT_ORDER_LSB +: 2] == 2'h3 && xaddr_q == $past(base_q) - $past(span))
        else $error("store stack map");
    a_coproc_scale: assert property (cls == ams_pkg::CL_COPROC && form == ams_pkg::FM_OFFSET && !up // RQ7
        |=> xaddr_q == $past(base_q) - {22'h000000, $past(imm8), 2'h0}) else $error("coprocessor offset scale");
    a_field_mask: assert property (pass ##1 pass // RQ8
        |-> stat_q[ams_pkg::STAT_FSEL_LSB +: 4] == $past(fmask)) else $error("field mask decode wrong");
    a_cond_always: assert property (cond == ams_pkg::cond_always |=> stat_q[ams_pkg::STAT_PASS_BIT]) // RQ9
        else $error("always predicate failed");
    a_fail_quiet: assert property (!pass |=> !stat_q[ams_pkg::STAT_XFER_BIT] && !stat_q[ams_pkg::STAT_WB_BIT] // RQ10
        && stat_q[ams_pkg::STAT_FSEL_LSB +: 4] == 4'h0) else $error("failed predicate has effect");
    a_half_reg_off: assert property (cls == ams_pkg::CL_HALF && use_reg && form == ams_pkg::FM_OFFSET && up // RQ11
        |=> xaddr_q == $past(base_q) + $past(index_q)) else $error("halfword index not unshifted");
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
    typedef struct packed {logic wr; logic err; logic [31:0] data; logic [31:0] mask;} ams_tb_exp_s;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    ams_tb_exp_s exp_q[$];
    ams_tb_exp_s ex;
    int          num_errors;
    int          checked;
    int          cycles;
    int          seed;
    logic [31:0] base;
    logic [31:0] idx;
    logic [3:0]  flg;
    logic        ok;
    logic [1:0]  ord;
    logic [31:0] mx;

    ams_addr_decode DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;

    task automatic conclude();
        if (exp_q.size() != 0) begin
            num_errors++;
            $display("FAIL %0t %0d transfers never completed", $time, exp_q.size());
        end
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // bounded so a stuck bus cannot hang the run
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            $display("FAIL %0t cycle limit reached", $time);
            conclude();
        end
    end

    // checks every completed transfer against the oldest queued note
    always @(posedge pclk) begin
        if (presetn && psel && penable && pready) begin
            checked++;
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("FAIL %0t unexpected transfer", $time);
            end else begin
                ex = exp_q.pop_front();
                if (pslverr !== ex.err || (!ex.wr && (prdata & ex.mask) !== (ex.data & ex.mask))) begin
                    num_errors++;
                    $display("FAIL %0t addr %h data %h err %b", $time, paddr, prdata, pslverr);
                end
            end
        end
    end

    // one apb transfer; the trailing idle cycle lets result registers settle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                        input logic er);
        exp_q.push_back('{w, er, d, m});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] cls, input logic [1:0] form, input logic up,
        input logic rg, input logic [1:0] sh, input logic usr, input logic ld, input logic [1:0] stk,
        input logic [3:0] cnd, input logic [3:0] msk);
        return {12'h000, msk, cnd, stk, ld, usr, sh, rg, up, form, cls};
    endfunction

    function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
        logic n, z, cy, v;
        {n, z, cy, v} = f;
        case (c)
            0: return z;            1: return !z;
            2: return cy;           3: return !cy;
            4: return n;            5: return !n;
            6: return v;            7: return !v;
            8: return cy && !z;     9: return !cy || z;
            10: return n == v;      11: return n != v;
            12: return !z && n == v;
            13: return z || n != v;
            default: return 1'b1;
        endcase
    endfunction

    // drives one address computation and checks address, writeback and status
    task automatic addr_case(input logic [1:0] cls, input logic [1:0] form, input logic up, input logic rg,
                             input logic [1:0] sh, input logic [4:0] amt, input logic [11:0] imm);
        logic [31:0] off;
        logic [31:0] wb;
        base = $random(seed);
        idx = $random(seed);
        if (cls == 2'd3) off = {22'h0, imm[7:0], 2'b00};
        else if (cls == 2'd1) off = rg ? idx : {24'h0, imm[7:0]};
        else if (!rg) off = {20'h0, imm};
        else case (sh)
            2'd0: off = idx << amt;
            2'd1: off = idx >> amt;
            2'd2: off = $signed(idx) >>> amt;
            default: off = (amt == 5'd0) ? {flg[1], idx[31:1]} : (idx >> amt) | (idx << (6'd32 - amt));
        endcase
        wb = up ? base + off : base - off;
        xfer(1'b1, 8'h08, base, 32'h0, 1'b0);
        xfer(1'b1, 8'h0c, idx, 32'h0, 1'b0);
        xfer(1'b1, 8'h04, {11'h0, amt, 4'h0, imm}, 32'h0, 1'b0);
        xfer(1'b1, 8'h00, ctl(cls, form, up, rg, sh, 1'b0, 1'b1, 2'd0, 4'he, 4'h0), 32'h0, 1'b0);
        xfer(1'b0, 8'h14, (form == 2'd2) ? base : wb, 32'hffff_ffff, 1'b0);
        if (form != 2'd0) xfer(1'b0, 8'h18, wb, 32'hffff_ffff, 1'b0);
        xfer(1'b0, 8'h1c, {28'h0, form != 2'd0, 3'b101}, 32'h0000_000f, 1'b0);
    endtask

    initial begin
        seed = 20764;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        pstrb = 4'hf;
        num_errors = 0;
        checked = 0;
        cycles = 0;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a < 5; a++) xfer(1'b0, 8'(a * 4), (a == 0) ? 32'h0000_e000 : 32'h0, 32'hffff_ffff, 1'b0);
        flg = 4'h2;
        xfer(1'b1, 8'h10, {28'h0, flg}, 32'h0, 1'b0);
        for (int k = 0; k < 3; k++) addr_case(2'd0, 2'(k), !k[0], 1'b0, 2'd0, 5'd0, 12'($random(seed)));
        for (int s = 0; s < 8; s++) addr_case(2'd0, 2'(1 + s[0]), s[1], 1'b1, 2'(s >> 1), 5'(1 + s * 4), 12'h0);
        addr_case(2'd0, 2'd2, 1'b1, 1'b1, 2'd3, 5'd0, 12'h0);
        for (int k = 0; k < 3; k++) addr_case(2'd1, 2'(k), k[0], 1'b0, 2'd0, 5'd0, 12'hf5a);
        addr_case(2'd1, 2'd1, 1'b0, 1'b1, 2'd0, 5'd3, 12'h0);
        addr_case(2'd1, 2'd0, 1'b1, 1'b1, 2'd0, 5'd0, 12'h0);
        for (int k = 0; k < 3; k++) addr_case(2'd3, 2'(k), k[0], 1'b0, 2'd0, 5'd0, 12'h3ff);
        for (int u = 1; u < 3; u++) begin
            xfer(1'b1, 8'h00, ctl(2'd0, 2'(u), 1'b1, 1'b0, 2'd0, 1'b1, 1'b0, 2'd0, 4'he, 4'h0), 32'h0, 1'b0);
            xfer(1'b0, 8'h1c, {30'h0, u == 1, 1'b0}, 32'h0000_0002, 1'b0);
        end
        // six registers so the span is 24 bytes
        xfer(1'b1, 8'h04, 32'h0600_0000, 32'h0, 1'b0);
        for (int m = 0; m < 8; m++) begin
            ord = m[2] ? 2'(m) : 2'(3 - m);
            case (ord)
                2'd0: mx = base;
                2'd1: mx = base + 32'h0000_0004;
                2'd2: mx = base - 32'h0000_0014;
                default: mx = base - 32'h0000_0018;
            endcase
            xfer(1'b1, 8'h00, ctl(2'd2, 2'd0, 1'b1, 1'b0, 2'd0, 1'b0, m[2], 2'(m), 4'he, 4'h0), 32'h0, 1'b0);
            xfer(1'b0, 8'h1c, {26'h0, ord, 4'h0}, 32'h0000_0030, 1'b0);
            xfer(1'b0, 8'h14, mx, 32'hffff_ffff, 1'b0);
            xfer(1'b0, 8'h18, ord[1] ? base - 32'h0000_0018 : base + 32'h0000_0018, 32'hffff_ffff, 1'b0);
        end
        for (int m = 0; m < 16; m++) begin
            xfer(1'b1, 8'h00, ctl(2'd0, 2'd0, 1'b1, 1'b0, 2'd0, 1'b0, 1'b0, 2'd0, 4'he, 4'(m)), 32'h0, 1'b0);
            xfer(1'b0, 8'h1c, {20'h0, 4'(m), 8'h0}, 32'h0000_0f00, 1'b0);
        end
        for (int c = 0; c < 15; c++) begin
            flg = 4'($random(seed));
            ok = cond_ok(4'(c), flg);
            xfer(1'b1, 8'h10, {28'h0, flg}, 32'h0, 1'b0);
            xfer(1'b1, 8'h00, ctl(2'd0, 2'd1, 1'b1, 1'b0, 2'd0, 1'b0, 1'b1, 2'd0, 4'(c), 4'h9), 32'h0, 1'b0);
            xfer(1'b0, 8'h1c, {20'h0, ok ? 4'h9 : 4'h0, 4'h0, ok, ok, 1'b0, ok}, 32'h0000_0f0f, 1'b0);
        end
        // result registers are read-only and unmapped places refuse
        xfer(1'b1, 8'h1c, 32'hffff_ffff, 32'h0, 1'b1);
        xfer(1'b1, 8'h24, 32'h1234_5678, 32'h0, 1'b1);
        xfer(1'b0, 8'h20, 32'h0, 32'hffff_ffff, 1'b1);
        xfer(1'b0, 8'h1c, 32'h0000_0900, 32'h0000_0ff0, 1'b0);
        // only the two low byte lanes of the base are written
        pstrb <= 4'h3;
        xfer(1'b1, 8'h08, 32'hffff_ffff, 32'h0, 1'b0);
        pstrb <= 4'hf;
        xfer(1'b0, 8'h08, {base[31:16], 16'hffff}, 32'hffff_ffff, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
